/* iapmc_pkg.sv */
// shared constants, state codes and decode helpers for the interrupt and power block
package iapmc_pkg;
  localparam int SRC_COUNT = 7;
  localparam int LEVEL_COUNT = 4;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  // register indices; byte address is four times the index
  localparam logic [7:0] ENABLE_IDX = 8'hA8;
  localparam logic [7:0] PRIO_HI_IDX = 8'hB7;
  localparam logic [7:0] PRIO_LO_IDX = 8'hB8;
  localparam logic [7:0] PWR_IDX = 8'h87;
  localparam logic [7:0] EXTCFG_IDX = 8'h88;
  localparam logic [7:0] STATUS_IDX = 8'hC0;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] PRIO_MASK = 8'h7F;
  localparam logic [7:0] PWR_MASK = 8'h03;
  localparam int GATE_BIT = 7;
  localparam int LIGHT_BIT = 0;
  localparam int DEEP_BIT = 1;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  localparam logic [15:0] VEC_SERIAL_B = 16'h0033;
  localparam int OSC_PERIOD_NS = 25;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_HOLD_OSC = 24;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LIGHT = 2'b01,
    ST_DEEP = 2'b10,
    ST_DEEP_WAKE = 2'b11
  } iapmc_state_e;
  // level from the high and low priority bits of one source
  function automatic logic [1:0] iapmc_level(input logic hi, input logic lo);
    return {hi, lo};
  endfunction : iapmc_level
  // mask of all levels at or above the given one
  function automatic logic [3:0] iapmc_ge_mask(input logic [1:0] lvl);
    return 4'(4'hF << lvl);
  endfunction : iapmc_ge_mask
endpackage : iapmc_pkg

/* iapmc_arb_if.sv */
// request and winner signals between the top and the priority resolver
`timescale 1ns/1ps
interface iapmc_arb_if;
  logic [6:0] req;
  logic [6:0] prio_hi;
  logic [6:0] prio_lo;
  logic win_valid;
  logic [2:0] win_idx;
  logic [1:0] win_level;
  modport arb (input req, input prio_hi, input prio_lo,
               output win_valid, output win_idx, output win_level);
  modport user (output req, output prio_hi, output prio_lo,
                input win_valid, input win_idx, input win_level);
endinterface : iapmc_arb_if

/* iapmc_arbiter.sv */
// four-level priority resolver with fixed polling order inside a level
`timescale 1ns/1ps
module iapmc_arbiter import iapmc_pkg::*; (
  iapmc_arb_if.arb arb
);
  logic [1:0] lvl [SRC_COUNT];

  // per-source level from its two priority bits
  for (genvar g = 0; g < SRC_COUNT; g++) begin : g_lvl
    assign lvl[g] = iapmc_level(arb.prio_hi[g], arb.prio_lo[g]); // R23
  end

  // highest level first, then lowest index wins the poll
  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_idx = 3'h0;
    arb.win_level = 2'h0;
    for (int l = LEVEL_COUNT - 1; l >= 0; l--) begin
      for (int s = 0; s < SRC_COUNT; s++) begin
        if (!arb.win_valid && arb.req[s] && lvl[s] == 2'(l)) begin // R25 R27
          arb.win_valid = 1'b1;
          arb.win_idx = 3'(s);
          arb.win_level = 2'(l);
        end
      end
    end
  end
endmodule : iapmc_arbiter

/* iapmc_top.sv */
// interrupt enable, priority and sleep-mode control with an axi4-lite register slave
`timescale 1ns/1ps
// Notes on behaviour
// R1: global gate off masks all; else per-source
// R2: enable bits 6..0, one per source
// R3: low priority bits same positions, bit 7 unused
// R4: high priority bits same positions form level
// R5: software never sets priority bit 7
// R6: light sleep entered right after setting bit
// R7: light sleep stops cpu clock only
// R8: light sleep keeps cpu state and pins
// R9: light sleep drives both strobes high
// R10: enabled interrupt clears light bit, wakes core
// R11: return resumes after the sleep instruction
// R12: reset completes after 24 oscillator periods
// R13: deep sleep stops oscillator after instruction
// R14: ram and registers kept in deep sleep
// R15: only external lines or reset leave deep
// R16: software enables and configures wake line
// R17: line low restarts oscillator, high exits
// R18: first line released exits, priority decides
// R19: return resumes after deep sleep instruction
// R20: reset exit clears registers, line exit keeps
// R21: no exit path alters internal ram
// R22: both bits set acts as deep, clears both
// R23: level is high bit then low bit
// R24: only higher level preempts running routine
// R25: simultaneous requests: highest level first, poll
// R26: second serial port vectors to 0033h
// R27: poll order ext0,t0,ext1,t1,sa,t2,sb
module iapmc_top import iapmc_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ext_irq_line_zero,
  input wire logic ext_irq_line_one,
  input wire logic timer_zero_irq,
  input wire logic timer_one_irq,
  input wire logic timer_two_irq,
  input wire logic serial_a_irq,
  input wire logic serial_b_irq,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic cpu_ale,
  input wire logic cpu_fetch_strobe,
  output logic irq_request,
  output logic [15:0] irq_vector,
  output logic [1:0] irq_level,
  output logic cpu_clock_en,
  output logic osc_run,
  output logic port_hold,
  output logic addr_latch_strobe,
  output logic code_fetch_strobe,
  output logic cpu_reset
);
  localparam logic [4:0] RST_CNT_MAX = 5'(RESET_HOLD_CYC);

  logic [7:0] irq_on_reg, prio_hi_reg, prio_lo_reg, pwr_reg;
  logic [1:0] ext_edge_reg;
  iapmc_state_e state_reg, state_next;
  logic [1:0] sync_a_reg, sync_b_reg, sync_c_reg, ext_level_reg, ext_old_reg;
  logic [1:0] ext_flag_reg, wake_src_reg, ext_req, ext_wake, wake_done, ext_clr, agree;
  logic [6:0] raw_req, eff_req;
  logic [3:0] active_mask_reg, active_next;
  logic [2:0] irq_src_reg;
  logic [4:0] rst_cnt_reg;
  logic aw_held_reg, w_held_reg, w_strb0_reg, wr_fire, grant_ok, light_exit, deep_exit;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg, wr_idx, rd_idx;

  iapmc_arb_if arb_bus();
  iapmc_arbiter u_arb (.arb(arb_bus));

  // known register at a word address; upper bits must be zero
  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[IDX_MSB:IDX_LSB];
    return (a[ADDR_W-1:IDX_MSB+1] == '0) &&
           (idx == ENABLE_IDX || idx == PRIO_HI_IDX || idx == PRIO_LO_IDX ||
            idx == PWR_IDX || idx == EXTCFG_IDX || idx == STATUS_IDX);
  endfunction : reg_known

  // three-stage synchroniser, lines idle high
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_a_reg <= 2'h3;
      sync_b_reg <= 2'h3;
      sync_c_reg <= 2'h3;
      ext_level_reg <= 2'h3;
      ext_old_reg <= 2'h3;
    end else begin
      sync_a_reg <= {ext_irq_line_one, ext_irq_line_zero};
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
      ext_level_reg <= (agree & sync_b_reg) | (~agree & ext_level_reg); // accept when stages agree
      ext_old_reg <= ext_level_reg;
    end
  end

  // request gating and wake terms
  assign agree = ~(sync_b_reg ^ sync_c_reg);
  assign ext_req = ext_flag_reg | (~ext_edge_reg & ~ext_level_reg);
  assign raw_req = {serial_b_irq, timer_two_irq, serial_a_irq, timer_one_irq,
                    ext_req[1], timer_zero_irq, ext_req[0]}; // R2
  assign eff_req = raw_req & irq_on_reg[6:0] & {SRC_COUNT{irq_on_reg[GATE_BIT]}}; // R1
  assign ext_wake = {irq_on_reg[SRC_EXT1], irq_on_reg[SRC_EXT0]} & {2{irq_on_reg[GATE_BIT]}}
                    & ~ext_level_reg; // R15 R16
  assign wake_done = wake_src_reg & ext_level_reg; // R17 R18
  assign arb_bus.req = eff_req;
  assign arb_bus.prio_hi = prio_hi_reg[6:0]; // R4
  assign arb_bus.prio_lo = prio_lo_reg[6:0]; // R3
  assign grant_ok = arb_bus.win_valid &&
                    (active_mask_reg & iapmc_ge_mask(arb_bus.win_level)) == 4'h0; // R24
  assign light_exit = (state_reg == ST_LIGHT) && (state_next == ST_RUN);
  assign deep_exit = (state_reg == ST_DEEP_WAKE) && (state_next == ST_RUN);

  // sleep state sequencing; deep wins when both bits are set
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (pwr_reg[DEEP_BIT]) state_next = ST_DEEP; // R13 R22
        else if (pwr_reg[LIGHT_BIT]) state_next = ST_LIGHT; // R6
      end
      ST_LIGHT: if (|eff_req) state_next = ST_RUN; // R10
      ST_DEEP: if (|ext_wake) state_next = ST_DEEP_WAKE; // R15 R17
      ST_DEEP_WAKE: if (|wake_done) state_next = ST_RUN; // R17 R18
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) state_reg <= ST_RUN;
    else state_reg <= state_next;
  end

  // power bits: software sets, hardware clears on wake
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pwr_reg <= PWR_RST;
    end else if (deep_exit) begin
      pwr_reg <= PWR_RST; // R22
    end else if (light_exit) begin
      pwr_reg[LIGHT_BIT] <= 1'b0; // R10
    end else if (wr_fire && wr_idx == PWR_IDX && w_strb0_reg) begin
      pwr_reg <= w_data_reg & PWR_MASK;
    end
  end

  // lines that pulled low while asleep, kept until the exit
  always_ff @(posedge clock or posedge reset) begin
    if (reset) wake_src_reg <= 2'h0;
    else if (state_reg == ST_DEEP || state_reg == ST_DEEP_WAKE)
      wake_src_reg <= (state_reg == ST_DEEP_WAKE ? wake_src_reg : 2'h0) | ext_wake;
    else wake_src_reg <= 2'h0;
  end

  // external pending flags; a set in the ack cycle is kept
  assign ext_clr = {irq_ack && irq_src_reg == SRC_EXT1, irq_ack && irq_src_reg == SRC_EXT0};
  always_ff @(posedge clock or posedge reset) begin
    if (reset) ext_flag_reg <= 2'h0;
    else ext_flag_reg <= (ext_flag_reg & ~ext_clr) | (ext_edge_reg & ext_old_reg & ~ext_level_reg)
                         | (deep_exit ? wake_src_reg : 2'h0); // R18
  end

  // request to the core, only while it runs; ack blocks a stale repeat
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_request <= 1'b0;
      irq_src_reg <= 3'h0;
      irq_level <= 2'h0;
      irq_vector <= VEC_BASE;
    end else begin
      irq_request <= grant_ok && state_reg == ST_RUN && state_next == ST_RUN && !irq_ack; // R24 R25
      irq_src_reg <= arb_bus.win_idx;
      irq_level <= arb_bus.win_level;
      irq_vector <= 16'(VEC_BASE + VEC_STEP * arb_bus.win_idx); // R26
    end
  end

  // in-service levels: push on ack, pop the highest on return
  always_comb begin
    active_next = active_mask_reg;
    if (irq_return) begin
      for (int l = 0; l < LEVEL_COUNT; l++) begin
        if (active_mask_reg[l] && (active_mask_reg & iapmc_ge_mask(2'(l))) == 4'(1 << l))
          active_next[l] = 1'b0; // R11 R19
      end
    end
    if (irq_ack && irq_request) active_next[irq_level] = 1'b1;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) active_mask_reg <= 4'h0;
    else active_mask_reg <= active_next;
  end

  // core-facing controls follow the next state so they change with it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cpu_clock_en <= 1'b1;
      osc_run <= 1'b1;
      port_hold <= 1'b0;
      addr_latch_strobe <= 1'b1;
      code_fetch_strobe <= 1'b1;
    end else begin
      cpu_clock_en <= state_next == ST_RUN; // R7 R8
      osc_run <= state_next != ST_DEEP; // R7 R13 R17
      port_hold <= state_next != ST_RUN; // R8 R14
      unique case (state_next)
        ST_RUN: begin
          addr_latch_strobe <= cpu_ale;
          code_fetch_strobe <= cpu_fetch_strobe;
        end
        ST_LIGHT: begin
          addr_latch_strobe <= 1'b1; // R9
          code_fetch_strobe <= 1'b1; // R9
        end
        ST_DEEP, ST_DEEP_WAKE: begin
          addr_latch_strobe <= 1'b0;
          code_fetch_strobe <= 1'b0;
        end
      endcase
    end
  end

  // core reset stretched so it always spans two machine cycles
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rst_cnt_reg <= 5'h00;
      cpu_reset <= 1'b1;
    end else begin
      if (rst_cnt_reg != RST_CNT_MAX) rst_cnt_reg <= rst_cnt_reg + 5'h01;
      cpu_reset <= rst_cnt_reg != RST_CNT_MAX; // R12 R20
    end
  end

  // write channels: address and data taken in either order, response after both
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
  assign wr_idx = aw_addr_reg[IDX_MSB:IDX_LSB];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 8'h00;
      w_strb0_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_reg <= awaddr;
        aw_held_reg <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_reg <= wdata[7:0];
        w_strb0_reg <= wstrb[0];
        w_held_reg <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= reg_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // software registers; contents survive every sleep exit except reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_on_reg <= ENABLE_RST; // R20
      prio_hi_reg <= PRIO_RST;
      prio_lo_reg <= PRIO_RST;
      ext_edge_reg <= 2'h0;
    end else if (wr_fire && w_strb0_reg) begin // R20 R21
      if (wr_idx == ENABLE_IDX) irq_on_reg <= w_data_reg; // R2
      if (wr_idx == PRIO_HI_IDX) prio_hi_reg <= w_data_reg & PRIO_MASK; // R4 R5
      if (wr_idx == PRIO_LO_IDX) prio_lo_reg <= w_data_reg & PRIO_MASK; // R3 R5
      if (wr_idx == EXTCFG_IDX) ext_edge_reg <= w_data_reg[1:0];
    end
  end

  // read channel: one cycle to data, unused bits read zero
  assign rd_idx = araddr[IDX_MSB:IDX_LSB];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata <= 32'h0000_0000;
      if (reg_known(araddr)) begin
        if (rd_idx == ENABLE_IDX) rdata[7:0] <= irq_on_reg;
        if (rd_idx == PRIO_HI_IDX) rdata[7:0] <= prio_hi_reg;
        if (rd_idx == PRIO_LO_IDX) rdata[7:0] <= prio_lo_reg;
        if (rd_idx == PWR_IDX) rdata[7:0] <= pwr_reg;
        if (rd_idx == EXTCFG_IDX) rdata[1:0] <= ext_edge_reg;
        if (rd_idx == STATUS_IDX) rdata[7:0] <= {state_reg, ext_level_reg, active_mask_reg};
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // checks on the sleep sequencing and the request path
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence deep_req_s;
    state_reg == ST_RUN ##0 pwr_reg[DEEP_BIT];
  endsequence
  sequence wake_release_s;
    state_reg == ST_DEEP_WAKE ##0 (|wake_done);
  endsequence
  gate_mask_a: assert property (!irq_on_reg[GATE_BIT] |=> !irq_request) // R1
    else $error("request passed with gate off");
  preempt_a: assert property (irq_request |->
    (active_mask_reg & iapmc_ge_mask(irq_level)) == 4'h0) // R24
    else $error("request not above running level");
  vector_a: assert property (irq_request && irq_src_reg == 3'h6 |->
    irq_vector == VEC_SERIAL_B) // R26
    else $error("wrong vector for second serial port");
  light_pins_a: assert property (state_reg == ST_LIGHT |->
    addr_latch_strobe && code_fetch_strobe && !cpu_clock_en && osc_run) // R9
    else $error("light sleep outputs wrong");
  light_wake_a: assert property (state_reg == ST_LIGHT && (|eff_req) |=>
    state_reg == ST_RUN && !pwr_reg[LIGHT_BIT] ##1 cpu_clock_en) // R10
    else $error("light sleep not left on interrupt");
  deep_entry_a: assert property (deep_req_s |=> !osc_run && !cpu_clock_en) // R13
    else $error("oscillator not stopped in deep sleep");
  deep_hold_a: assert property (state_reg == ST_DEEP && !(|ext_wake) |=>
    state_reg == ST_DEEP) // R15
    else $error("deep sleep left without line");
  deep_exit_a: assert property (wake_release_s |=> state_reg == ST_RUN &&
    pwr_reg == PWR_RST && ext_flag_reg != 2'h0) // R17
    else $error("deep sleep exit incomplete");
  reset_hold_a: assert property ($fell(cpu_reset) |-> rst_cnt_reg == RST_CNT_MAX) // R12
    else $error("core reset released early");
endmodule : iapmc_top

/* iapmc_core_model.sv */
// cpu core stand-in: takes interrupt requests, returns on command, toggles strobes
`timescale 1ns/1ps
module iapmc_core_model import iapmc_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0] irq_level,
  input wire logic cpu_clock_en,
  input wire logic ret_go,
  input wire logic [3:0] ack_wait,
  output logic irq_ack,
  output logic irq_return,
  output logic cpu_ale,
  output logic cpu_fetch_strobe,
  output logic [15:0] last_vec,
  output logic [1:0] last_lvl
);
  logic [3:0] wait_reg;
  logic [1:0] strobe_reg;

  // ack a standing request after ack_wait cycles; a gated core takes nothing
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_ack <= 1'b0;
      wait_reg <= 4'h0;
      last_vec <= 16'h0000;
      last_lvl <= 2'h0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      wait_reg <= 4'h0;
    end else if (irq_request && cpu_clock_en) begin
      if (wait_reg >= ack_wait) begin
        irq_ack <= 1'b1;
        last_vec <= irq_vector;
        last_lvl <= irq_level;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end

  // return from service only when the bench says the routine is over
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_return <= 1'b0;
    end else begin
      irq_return <= ret_go;
    end
  end

  // strobes toggle while clocked and park low when gated, so a forced high shows
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      strobe_reg <= 2'h0;
    end else if (cpu_clock_en) begin
      strobe_reg <= strobe_reg + 2'h1;
    end
  end
  assign cpu_ale = strobe_reg[0] & cpu_clock_en;
  assign cpu_fetch_strobe = strobe_reg[1] & cpu_clock_en;
endmodule : iapmc_core_model

/* interrupt_and_power_mode_control_tb_top.sv */
// self-checking bench for the interrupt and power block
`timescale 1ns/1ps
module interrupt_and_power_mode_control_tb_top import iapmc_pkg::*;;
  logic clock, reset, awvalid, wvalid, bready, arvalid, rready, ret_go;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, ack_wait;
  logic [6:0] src;
  logic awready, wready, bvalid, arready, rvalid, irq_ack, irq_return, cpu_ale;
  logic cpu_fetch_strobe, irq_request, cpu_clock_en, osc_run, port_hold, cpu_reset;
  logic addr_latch_strobe, code_fetch_strobe;
  logic [1:0] bresp, rresp, irq_level, last_lvl;
  logic [15:0] irq_vector, last_vec;
  int n_mismatch, checks_done, cyc, n;
  int ord [7] = '{6, 3, 0, 1, 2, 4, 5};
  logic [1:0] lvl_tab [7] = '{2'h3, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};

  // source bit i is request index i; external lines are active low
  iapmc_top DUT (.clock, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .ext_irq_line_zero(~src[0]), .ext_irq_line_one(~src[2]),
    .timer_zero_irq(src[1]), .timer_one_irq(src[3]), .timer_two_irq(src[5]),
    .serial_a_irq(src[4]), .serial_b_irq(src[6]), .irq_ack, .irq_return, .cpu_ale,
    .cpu_fetch_strobe, .irq_request, .irq_vector, .irq_level, .cpu_clock_en, .osc_run,
    .port_hold, .addr_latch_strobe, .code_fetch_strobe, .cpu_reset);

  iapmc_core_model core (.clock, .reset, .irq_request, .irq_vector, .irq_level,
    .cpu_clock_en, .ret_go, .ack_wait, .irq_ack, .irq_return, .cpu_ale,
    .cpu_fetch_strobe, .last_vec, .last_lvl);

  always #12.5 clock = ~clock;

  // hang guard: generous against the few hundred cycles used
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one word write; aw and w offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    awaddr <= ADDR_W'({idx, 2'b00});
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
    araddr <= ADDR_W'({idx, 2'b00});
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, {24'h0, ed});
    chk(32'(rresp), 32'(er));
  endtask : rd

  // wait for the core to take a request, then drop that source's request
  task automatic take(input int i, input logic [1:0] el);
    do @(posedge clock); while (irq_ack !== 1'b1);
    chk(32'(last_vec), 32'(VEC_BASE + VEC_STEP * i));
    chk(32'(last_lvl), 32'(el));
    src[i] <= 1'b0;
  endtask : take

  // delay the return so a released external line has passed its synchroniser
  task automatic ret();
    repeat (6) @(posedge clock);
    ret_go <= 1'b1;
    @(posedge clock);
    ret_go <= 1'b0;
  endtask : ret

  task automatic quiet();
    repeat (8) @(posedge clock);
    chk(32'(irq_request), 32'h0);
  endtask : quiet

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    {clock, awvalid, wvalid, bready, arvalid, rready, ret_go} = '0;
    {awaddr, araddr, wdata, src, ack_wait, n_mismatch, checks_done, cyc} = '0;
    reset = 1'b1;
    wstrb = 4'hF;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    n = 0;
    while (cpu_reset === 1'b1 && n < 100) begin
      n++;
      @(posedge clock);
    end
    chk(32'(n), 32'(RESET_HOLD_CYC + 1));
    rd(ENABLE_IDX, ENABLE_RST, RESP_OKAY);
    rd(STATUS_IDX, 8'h30, RESP_OKAY);
    rd(PRIO_HI_IDX, PRIO_RST, RESP_OKAY);
    rd(PRIO_LO_IDX, PRIO_RST, RESP_OKAY);
    rd(PWR_IDX, PWR_RST, RESP_OKAY);
    wr(PRIO_HI_IDX, 8'h55, RESP_OKAY);
    rd(PRIO_HI_IDX, 8'h55, RESP_OKAY);
    wr(PRIO_LO_IDX, 8'h7F, RESP_OKAY);
    rd(PRIO_LO_IDX, 8'h7F, RESP_OKAY);
    wr(8'h10, 8'h5A, RESP_SLVERR);
    rd(8'h10, 8'h00, RESP_SLVERR);
    done("registers");
    wr(ENABLE_IDX, 8'h02, RESP_OKAY);
    src[1] <= 1'b1;
    quiet();
    wr(ENABLE_IDX, 8'h82, RESP_OKAY);
    take(1, 2'h1);
    ret();
    done("gate");
    wr(PRIO_HI_IDX, 8'h48, RESP_OKAY);
    wr(PRIO_LO_IDX, 8'h40, RESP_OKAY);
    wr(ENABLE_IDX, 8'hFF, RESP_OKAY);
    ack_wait <= 4'h5;
    src <= 7'h7F;
    foreach (ord[k]) begin
      take(ord[k], lvl_tab[k]);
      ret();
    end
    ack_wait <= 4'h0;
    done("polling");
    wr(PRIO_LO_IDX, 8'h00, RESP_OKAY);
    wr(PRIO_HI_IDX, 8'h40, RESP_OKAY);
    src[1] <= 1'b1;
    take(1, 2'h0);
    src[3] <= 1'b1;
    quiet();
    src[6] <= 1'b1;
    take(6, 2'h2);
    ret();
    ret();
    take(3, 2'h0);
    ret();
    done("preemption");
    wr(ENABLE_IDX, 8'hA0, RESP_OKAY);
    wr(PWR_IDX, 8'h01, RESP_OKAY);
    repeat (4) @(posedge clock);
    chk(32'({cpu_clock_en, osc_run, port_hold}), 32'h3);
    repeat (4) begin
      @(posedge clock);
      chk(32'({addr_latch_strobe, code_fetch_strobe}), 32'h3);
    end
    src[5] <= 1'b1;
    take(5, 2'h0);
    chk(32'(cpu_clock_en), 32'h1);
    ret();
    rd(PWR_IDX, 8'h00, RESP_OKAY);
    done("light sleep");
    wr(ENABLE_IDX, 8'h83, RESP_OKAY);
    wr(PWR_IDX, 8'h03, RESP_OKAY);
    repeat (4) @(posedge clock);
    chk(32'({osc_run, cpu_clock_en, addr_latch_strobe, code_fetch_strobe}), 32'h0);
    src[1] <= 1'b1;
    repeat (10) @(posedge clock);
    chk(32'(osc_run), 32'h0);
    src[0] <= 1'b1;
    n = 0;
    while (osc_run !== 1'b1 && n < 12) begin
      n++;
      @(posedge clock);
    end
    chk(32'({osc_run, cpu_clock_en}), 32'h2);
    repeat (4) @(posedge clock);
    src[0] <= 1'b0;
    take(0, 2'h0);
    ret();
    take(1, 2'h0);
    ret();
    rd(PWR_IDX, 8'h00, RESP_OKAY);
    rd(ENABLE_IDX, 8'h83, RESP_OKAY);
    done("deep sleep");
    // a short low pulse with the gate shut must stay pending in edge mode
    wr(ENABLE_IDX, 8'h01, RESP_OKAY);
    wr(EXTCFG_IDX, 8'h01, RESP_OKAY);
    rd(EXTCFG_IDX, 8'h01, RESP_OKAY);
    src[0] <= 1'b1;
    repeat (4) @(posedge clock);
    src[0] <= 1'b0;
    repeat (8) @(posedge clock);
    wr(ENABLE_IDX, 8'h81, RESP_OKAY);
    take(0, 2'h0);
    ret();
    quiet();
    done("edge mode");
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(ENABLE_IDX, ENABLE_RST, RESP_OKAY);
    rd(PRIO_HI_IDX, PRIO_RST, RESP_OKAY);
    done("reset");
    finish_test();
  end
endmodule : interrupt_and_power_mode_control_tb_top
